// *** lgp_port_e_defs.svh ***
// register offsets, field positions, reset values for the shared lcd/gpio port e
// assumes an 8-bit register port with a 3-bit word address
`ifndef LGP_PORT_E_DEFS_SVH
`define LGP_PORT_E_DEFS_SVH

`define LGP_OFF_PIN_LEVELS     3'h0
`define LGP_OFF_OUTPUT_LATCH   3'h1
`define LGP_OFF_DIRECTION      3'h2
`define LGP_OFF_PORT_G_PINS    3'h3
`define LGP_OFF_PORT_G_DIR     3'h4
`define LGP_OFF_LCD_CONTROL    3'h5
`define LGP_OFF_LCD_SEG_EN_3   3'h6

`define LGP_PIN_MASK           8'hfb
`define LGP_DIR_RST            8'hfb
`define LGP_LATCH_RST          8'h00
`define LGP_LCD_CONTROL_RST         8'h00
`define LGP_SEGEN_RST          8'h00
`define LGP_LCD_CONTROL_MASK        8'hef

`define LGP_PULLUP_BIT         6
`define LGP_OPEN_DRAIN_BIT     6
`define LGP_LCD_ENABLE_BIT     7
`define LGP_LMUX_LSB           0
`define LGP_LCD_SEGMENT_31_BIT          7
`define LGP_CCP_PIN            7
`define LGP_COM_FIRST_PIN      3
`define LGP_COM_COUNT          4
`define LGP_NO_PIN             2

`endif

// *** lgp_port_e_pkg.sv ***
// types for the shared lcd/gpio port e
// assumes the constants header is included by the files that need it
package lgp_port_e_pkg;

  typedef enum logic [1:0] {
    LGP_FN_PORT,
    LGP_FN_CCP,
    LGP_FN_LCD,
    LGP_FN_NONE
  } lgp_pin_fn_e;

  typedef struct packed {
    logic       rst_s1;
    logic [7:0] latch;
    logic [7:0] dir;
    logic       pu_en;
    logic       od;
    logic [7:0] lcd_control;
    logic [7:0] segen;
    logic [7:0] rdata;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic       fuse_s1;
    logic       fuse_s2;
    logic [7:0] pin_o;
    logic [7:0] oe_n;
    logic [7:0] pu_o;
    logic [7:0] lcd_own;
    logic       capture;
  } lgp_state_s;

endpackage

// *** lgp_port_e.sv ***
// seven-pin general-purpose port e with lcd common, bias, segment and
// capture/compare channel two pin sharing, plus its register port.
// assumes pins, pull-ups and the pin-map fuse come from outside the clock domain;
// the compare channel and the lcd controller run on SYS_CLK_I.
//
// Summary of operation
// [R1] seven pins at bits 0,1,3-7; no bit 2
// [R2] each pin has its own direction bit
// [R3] direction 0 drives latch, 1 floats, reads pin
// [R4] pin or latch write loads latch; reads differ
// [R5] any reset sets all pins as inputs
// [R6] one shared bit enables all weak pull-ups
// [R7] output pins never get a pull-up
// [R8] reset clears the shared pull-up enable
// [R9] open-drain bit makes channel pin drive low only
// [R10] multiplex field claims commons on pins 3-6
// [R11] active commons override driver and other functions
// [R12] pins 0,1 are bias inputs when lcd on
// [R13] bit 2 position is bias three only
// [R14] segment 31 on pin 7 overrides port
// [R15] channel two on pin 7 when fuse clear
// [R16] direction picks compare output or capture input
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "lgp_port_e_defs.svh"

module lgp_port_e #(
  parameter int ADDR_W = 3
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [7:0]        RDATA_O,
  input  wire logic [7:0]        PIN_I,
  output logic      [7:0]        PIN_O,
  output logic      [7:0]        PIN_OE_N_O,
  output logic      [7:0]        PULLUP_EN_O,
  output logic      [7:0]        LCD_OWN_O,
  input  wire logic              CHANNEL_TWO_PIN_MAP_FUSE_I,
  input  wire logic              CCP_OUT_I,
  input  wire logic              CCP_OUT_EN_I,
  output logic                   CCP_CAPTURE_O
);
  import lgp_port_e_pkg::*;

  generate
    if (ADDR_W < 3) begin : g_bad_addr
      $error("lgp_port_e: ADDR_W must be at least 3");
    end
  endgenerate

  localparam lgp_state_s ST_RST = '{
    rst_s1:  1'b0,
    latch:   `LGP_LATCH_RST,
    dir:     `LGP_DIR_RST,
    pu_en:   1'b0,
    od:      1'b0,
    lcd_control:  `LGP_LCD_CONTROL_RST,
    segen:   `LGP_SEGEN_RST,
    rdata:   8'h00,
    pin_s1:  8'h00,
    pin_s2:  8'h00,
    fuse_s1: 1'b1,
    fuse_s2: 1'b1,
    pin_o:   8'h00,
    oe_n:    8'hff,
    pu_o:    8'h00,
    lcd_own: 8'h00,
    capture: 1'b0
  };

  localparam logic [7:0] PIN_MASK = `LGP_PIN_MASK;

  lgp_state_s  st_reg;
  lgp_state_s  st_next;
  logic        rst_n_reg;
  logic        rst_n;

  // reset is released through two flops; the first takes a constant, the second takes the first
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_n_reg <= 1'b0;
    end else begin
      rst_n_reg <= 1'b1;
    end
  end

  logic rst_s2_reg;
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s2_reg <= rst_n_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // decoded address, wide address bits above the map make the access unmapped
  logic       addr_hit;
  logic [2:0] addr_w;
  assign addr_w   = ADDR_I[2:0];
  assign addr_hit = (ADDR_I >> 3) == '0;

  logic        ccp_mapped;
  logic [7:0]  com_act;
  logic        bias_act;
  logic        seg_act;
  lgp_pin_fn_e fn;
  logic        drv_val;
  logic [7:0]  rd_mux;
  logic [1:0]  lmux;

  always_comb begin
    st_next    = st_reg;
    ccp_mapped = 1'b0;
    com_act    = 8'h00;
    bias_act   = 1'b0;
    seg_act    = 1'b0;
    fn         = LGP_FN_NONE;
    drv_val    = 1'b0;
    rd_mux     = 8'h00;
    lmux       = st_reg.lcd_control[`LGP_LMUX_LSB +: 2];

    st_next.rst_s1  = 1'b1;
    // first stage only feeds the second stage
    st_next.pin_s1  = PIN_I;
    st_next.pin_s2  = st_reg.pin_s1;
    st_next.fuse_s1 = CHANNEL_TWO_PIN_MAP_FUSE_I;
    st_next.fuse_s2 = st_reg.fuse_s1;

    // register writes
    if (WR_I && addr_hit) begin
      case (addr_w)
        `LGP_OFF_PIN_LEVELS,
        `LGP_OFF_OUTPUT_LATCH: st_next.latch = WDATA_I & `LGP_PIN_MASK; // R4 R1
        `LGP_OFF_DIRECTION:    st_next.dir   = WDATA_I & `LGP_PIN_MASK; // R2 R1
        `LGP_OFF_PORT_G_PINS:  st_next.pu_en = WDATA_I[`LGP_PULLUP_BIT]; // R6
        `LGP_OFF_PORT_G_DIR:   st_next.od    = WDATA_I[`LGP_OPEN_DRAIN_BIT]; // R9
        `LGP_OFF_LCD_CONTROL:  st_next.lcd_control = WDATA_I & `LGP_LCD_CONTROL_MASK;
        `LGP_OFF_LCD_SEG_EN_3: st_next.segen = WDATA_I;
        default: ;
      endcase
    end

    // reads: data stands one cycle, zero otherwise and for unmapped words
    case (addr_w)
      `LGP_OFF_PIN_LEVELS:   rd_mux = st_reg.pin_s2 & `LGP_PIN_MASK; // R3 R4
      `LGP_OFF_OUTPUT_LATCH: rd_mux = st_reg.latch; // R4
      `LGP_OFF_DIRECTION:    rd_mux = st_reg.dir;
      `LGP_OFF_PORT_G_PINS:  rd_mux = {1'b0, st_reg.pu_en, 6'h00};
      `LGP_OFF_PORT_G_DIR:   rd_mux = {1'b0, st_reg.od, 6'h00};
      `LGP_OFF_LCD_CONTROL:  rd_mux = st_reg.lcd_control;
      `LGP_OFF_LCD_SEG_EN_3: rd_mux = st_reg.segen;
      default:               rd_mux = 8'h00;
    endcase
    st_next.rdata = (RD_I && addr_hit) ? rd_mux : 8'h00;

    // pin sharing
    ccp_mapped = !st_reg.fuse_s2; // R15
    bias_act   = st_reg.lcd_control[`LGP_LCD_ENABLE_BIT]; // R12
    seg_act    = st_reg.segen[`LGP_LCD_SEGMENT_31_BIT]; // R14
    for (int k = 0; k < `LGP_COM_COUNT; k++) begin
      // code n claims commons 0..n on pins 3..3+n
      com_act[`LGP_COM_FIRST_PIN + k] = bias_act && (k <= int'(lmux)); // R10
    end

    for (int i = 0; i < 8; i++) begin
      if (!PIN_MASK[i]) begin
        fn = LGP_FN_NONE; // R13
      end else if (com_act[i] || (bias_act && i < 2) || (seg_act && i == `LGP_LCD_SEGMENT_31_BIT)) begin
        fn = LGP_FN_LCD; // R11 R12 R14
      end else if (i == `LGP_CCP_PIN && ccp_mapped && CCP_OUT_EN_I) begin
        fn = LGP_FN_CCP; // R15
      end else begin
        fn = LGP_FN_PORT;
      end
      case (fn)
        LGP_FN_PORT: begin
          drv_val            = st_reg.latch[i];
          st_next.pin_o[i]   = drv_val; // R3
          st_next.oe_n[i]    = st_reg.dir[i]; // R2 R3
          st_next.lcd_own[i] = 1'b0;
        end
        LGP_FN_CCP: begin
          drv_val            = CCP_OUT_I; // R16
          // open drain: a high level releases the pin instead of driving it
          st_next.pin_o[i]   = st_reg.od ? 1'b0 : drv_val; // R9
          st_next.oe_n[i]    = st_reg.dir[i] | (st_reg.od & drv_val); // R9 R16
          st_next.lcd_own[i] = 1'b0;
        end
        LGP_FN_LCD: begin
          st_next.pin_o[i]   = 1'b0;
          st_next.oe_n[i]    = 1'b1; // R11
          st_next.lcd_own[i] = 1'b1;
        end
        default: begin
          st_next.pin_o[i]   = 1'b0;
          st_next.oe_n[i]    = 1'b1; // R13
          st_next.lcd_own[i] = (i == `LGP_NO_PIN) && bias_act;
        end
      endcase
      // pull-ups only on port and channel inputs
      st_next.pu_o[i] = st_reg.pu_en && st_reg.dir[i] && (fn == LGP_FN_PORT || fn == LGP_FN_CCP); // R6 R7
    end

    st_next.capture = ccp_mapped && st_reg.dir[`LGP_CCP_PIN] && !seg_act
                      && st_reg.pin_s2[`LGP_CCP_PIN]; // R16
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RST; // R5 R8
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA_O       = st_reg.rdata;
  assign PIN_O         = st_reg.pin_o;
  assign PIN_OE_N_O    = st_reg.oe_n;
  assign PULLUP_EN_O   = st_reg.pu_o;
  assign LCD_OWN_O     = st_reg.lcd_own;
  assign CCP_CAPTURE_O = st_reg.capture;

  // ---- checks ----
  sequence s_write_latch;
    WR_I && addr_hit && addr_w == `LGP_OFF_PIN_LEVELS;
  endsequence

  sequence s_read_latch;
    RD_I && addr_hit && addr_w == `LGP_OFF_OUTPUT_LATCH;
  endsequence

  property p_write_then_read;
    logic [7:0] d;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      (s_write_latch, d = WDATA_I) ##1 s_read_latch |=> RDATA_O == (d & `LGP_PIN_MASK);
  endproperty

  a_latch_write_read: assert property (p_write_then_read) // R4
    else $error("latch read does not return value written through pin register");

  a_read_data_idle: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R4
      !RD_I |=> RDATA_O == 8'h00)
    else $error("read data not zero outside read answer cycle");

  a_reset_dirs_input: assert property (@(posedge SYS_CLK_I) // R5
      $rose(rst_n) |-> st_reg.dir == `LGP_DIR_RST && !st_reg.pu_en && PIN_OE_N_O == 8'hff)
    else $error("port not all inputs with pull-ups off after reset");

  a_reset_pullup_off: assert property (@(posedge SYS_CLK_I) // R8
      $rose(rst_n) |-> PULLUP_EN_O == 8'h00)
    else $error("pull-ups on after reset");

  a_output_no_pullup: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R7
      1'b1 |=> (PULLUP_EN_O & ~$past(st_reg.dir)) == 8'h00)
    else $error("pull-up on an output pin");

  a_shared_pullup_off: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R6
      !st_reg.pu_en |=> PULLUP_EN_O == 8'h00)
    else $error("pull-up on while shared enable clear");

  a_bit2_never_io: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R13 R1
      PIN_OE_N_O[`LGP_NO_PIN] && !PULLUP_EN_O[`LGP_NO_PIN] && !PIN_O[`LGP_NO_PIN])
    else $error("bit 2 position used as digital io");

  a_no_pin_bits: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R1
      !st_reg.dir[`LGP_NO_PIN] && !st_reg.latch[`LGP_NO_PIN])
    else $error("bit 2 stored in direction or latch");

  sequence s_write_dir;
    WR_I && addr_hit && addr_w == `LGP_OFF_DIRECTION;
  endsequence

  a_dir_write_loads: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R2 R1
      s_write_dir |=> st_reg.dir == ($past(WDATA_I) & `LGP_PIN_MASK))
    else $error("direction write not taken");

  a_input_floats: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R3 R2
      1'b1 |=> (~PIN_OE_N_O & $past(st_reg.dir)) == 8'h00)
    else $error("pin with direction set is driven");

  a_all_commons: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R10
      st_reg.lcd_control[`LGP_LCD_ENABLE_BIT] && lmux == 2'b11 |=> PIN_OE_N_O[6:3] == 4'hf && LCD_OWN_O[6:3] == 4'hf)
    else $error("all four commons not claimed");

  a_one_common: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R10 R11
      st_reg.lcd_control[`LGP_LCD_ENABLE_BIT] && lmux == 2'b00 && st_reg.dir[4] == 1'b0 |=> !PIN_OE_N_O[4] && PIN_OE_N_O[3])
    else $error("single common mode wrong on pins 3 and 4");

  a_two_commons: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R10
      bias_act && lmux == 2'b01 && !st_reg.dir[5] |=> LCD_OWN_O[5:3] == 3'b011 && !PIN_OE_N_O[5])
    else $error("two common mode wrong on pins 3 to 5");

  a_three_commons: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R10
      bias_act && lmux == 2'b10 && !st_reg.dir[6] |=> LCD_OWN_O[6:3] == 4'b0111 && !PIN_OE_N_O[6])
    else $error("three common mode wrong on pins 3 to 6");

  a_common_owns_pin: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R11
      1'b1 |=> (PIN_OE_N_O & $past(com_act)) == $past(com_act) && (PULLUP_EN_O & $past(com_act)) == 8'h00)
    else $error("active common pin still used by the port");

  a_bias_pins: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R12
      st_reg.lcd_control[`LGP_LCD_ENABLE_BIT] |=> PIN_OE_N_O[1:0] == 2'b11 && PULLUP_EN_O[1:0] == 2'b00)
    else $error("bias pins driven while lcd on");

  a_bias_three_own: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R13 R12
      bias_act |=> LCD_OWN_O[`LGP_NO_PIN])
    else $error("third bias position not given to lcd");

  a_lcd_released: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R11 R14
      !bias_act && !seg_act |=> LCD_OWN_O == 8'h00)
    else $error("lcd still owns a pin while lcd functions are off");

  a_lcd_segment_31_override: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R14
      st_reg.segen[`LGP_LCD_SEGMENT_31_BIT] |=> PIN_OE_N_O[7] && LCD_OWN_O[7] && !CCP_CAPTURE_O)
    else $error("segment 31 not overriding pin 7");

  a_open_drain_high: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R9
      ccp_mapped && CCP_OUT_EN_I && st_reg.od && CCP_OUT_I && !seg_act && !st_reg.dir[7] |=> PIN_OE_N_O[7])
    else $error("open-drain pin driven high");

  a_ccp_priority: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R16
      ccp_mapped && CCP_OUT_EN_I && !st_reg.od && !seg_act && !st_reg.dir[7]
      |=> !PIN_OE_N_O[7] && PIN_O[7] == $past(CCP_OUT_I))
    else $error("compare output not on pin 7");

  a_capture_follows: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R16
      ccp_mapped && st_reg.dir[`LGP_CCP_PIN] && !seg_act |=> CCP_CAPTURE_O == $past(st_reg.pin_s2[`LGP_CCP_PIN]))
    else $error("capture input not following pin 7");

  a_capture_idle: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R15
      !ccp_mapped |=> !CCP_CAPTURE_O)
    else $error("capture input active while channel mapped away");

  a_ccp_unmapped: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R15 R3
      st_reg.fuse_s2 && !seg_act && !st_reg.dir[7] |=> PIN_O[7] == $past(st_reg.latch[7]) && !CCP_CAPTURE_O)
    else $error("pin 7 not port while channel mapped away");

  a_port_drive: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n) // R3 R2
      !bias_act && !st_reg.dir[0] |=> !PIN_OE_N_O[0] && PIN_O[0] == $past(st_reg.latch[0]))
    else $error("pin 0 not driven from latch");

endmodule // lgp_port_e

// *** lgp_pin_board_model.sv ***
// board model of the port pins: design drive, outside sources, weak pull-ups
// assumes active-low output enables and active-high pull-up requests
`timescale 1ns/1ps
module lgp_pin_board_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pin_level_o
);
  logic [7:0] float_pat = 8'h55;
  // an undriven pin wanders, so a stale level never reads back as valid
  always @(posedge clk_i) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i]) pin_level_o[i] = pin_o_i[i];
      else if (ext_en_i[i]) pin_level_o[i] = ext_val_i[i];
      else if (pullup_i[i]) pin_level_o[i] = 1'b1;
      else pin_level_o[i] = float_pat[i];
    end
  end
endmodule // lgp_pin_board_model

// *** tb.sv ***
// self-checking bench for the shared lcd/gpio port e
// assumes the port design and the pin board model; one clock, fixed stimulus
`timescale 1ns/1ps
`include "lgp_port_e_defs.svh"
module tb;
  logic       clk, rst_n, wr, rd, fuse, ccp_out, ccp_en, capture;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, pin_in, pin_out, oe_n, pu, own, ext_val, ext_en;
  int         failures = 0;
  int         checked = 0;
  int         cycles = 0;

  lgp_port_e u_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_N_O(oe_n),
    .PULLUP_EN_O(pu), .LCD_OWN_O(own), .CHANNEL_TWO_PIN_MAP_FUSE_I(fuse), .CCP_OUT_I(ccp_out),
    .CCP_OUT_EN_I(ccp_en), .CCP_CAPTURE_O(capture));
  lgp_pin_board_model u_board (.clk_i(clk), .pin_o_i(pin_out), .oe_n_i(oe_n), .pullup_i(pu),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_level_o(pin_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // write then read with no idle cycle between the strobes
  task automatic wr_rd_chk(input logic [2:0] wa, input logic [7:0] d, input logic [2:0] ra, input logic [7:0] exp);
    @(posedge clk);
    addr <= wa;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= ra;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // covers the output flop plus the two-flop pin and fuse synchronisers
  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    #1 chk(oe_n, 8'hff);
    chk(pu, 8'h00);
    chk(own, 8'h00);
    rd_chk(`LGP_OFF_DIRECTION, 8'hfb);
    rd_chk(`LGP_OFF_OUTPUT_LATCH, 8'h00);
    rd_chk(`LGP_OFF_PORT_G_PINS, 8'h00);
    rd_chk(`LGP_OFF_PORT_G_DIR, 8'h00);
    rd_chk(`LGP_OFF_LCD_CONTROL, 8'h00);
    rd_chk(`LGP_OFF_LCD_SEG_EN_3, 8'h00);
  endtask

  task automatic t_latch_dir;
    wr_rd_chk(`LGP_OFF_PIN_LEVELS, 8'h3c, `LGP_OFF_OUTPUT_LATCH, 8'h38);
    wr_reg(`LGP_OFF_PIN_LEVELS, 8'hff);
    rd_chk(`LGP_OFF_OUTPUT_LATCH, 8'hfb);
    wr_reg(`LGP_OFF_DIRECTION, 8'h00);
    settle();
    chk(oe_n, 8'h04);
    chk(pin_out & 8'hfb, 8'hfb);
    rd_chk(`LGP_OFF_PIN_LEVELS, 8'hfb);
    wr_reg(`LGP_OFF_OUTPUT_LATCH, 8'h5a);
    wr_reg(`LGP_OFF_DIRECTION, 8'hf0);
    ext_val <= 8'h90;
    ext_en <= 8'hf0;
    settle();
    chk(oe_n, 8'hf4);
    rd_chk(`LGP_OFF_PIN_LEVELS, 8'h9a);
    rd_chk(`LGP_OFF_OUTPUT_LATCH, 8'h5a);
    rd_chk(`LGP_OFF_DIRECTION, 8'hf0);
  endtask

  task automatic t_pullup;
    ext_en <= 8'h00;
    wr_reg(`LGP_OFF_PORT_G_PINS, 8'h40);
    settle();
    chk(pu, 8'hf0);
    rd_chk(`LGP_OFF_PORT_G_PINS, 8'h40);
    rd_chk(`LGP_OFF_PIN_LEVELS, 8'hfa);
    wr_reg(`LGP_OFF_PORT_G_PINS, 8'h00);
    settle();
    chk(pu, 8'h00);
  endtask

  task automatic t_lcd;
    logic [7:0] e;
    wr_reg(`LGP_OFF_DIRECTION, 8'h00);
    for (int c = 0; c < 4; c++) begin
      e = 8'h07 | ((8'h0f >> (3 - c)) << 3);
      wr_reg(`LGP_OFF_LCD_CONTROL, 8'h80 | 8'(c));
      settle();
      chk(own, e);
      chk(oe_n, e);
      rd_chk(`LGP_OFF_LCD_CONTROL, 8'h80 | 8'(c));
    end
    wr_reg(`LGP_OFF_LCD_CONTROL, 8'h00);
    settle();
    chk(own, 8'h00);
  endtask

  task automatic t_ccp;
    wr_reg(`LGP_OFF_LCD_SEG_EN_3, 8'h80);
    fuse <= 1'b0;
    ccp_en <= 1'b1;
    ccp_out <= 1'b1;
    settle();
    chk(own, 8'h80);
    chk(oe_n, 8'h84);
    wr_reg(`LGP_OFF_LCD_SEG_EN_3, 8'h00);
    settle();
    chk({7'h00, pin_out[7]}, 8'h01);
    chk(oe_n, 8'h04);
    wr_reg(`LGP_OFF_PORT_G_DIR, 8'h40);
    settle();
    chk(oe_n, 8'h84);
    ccp_out <= 1'b0;
    settle();
    chk(oe_n, 8'h04);
    chk({7'h00, pin_out[7]}, 8'h00);
    wr_reg(`LGP_OFF_PORT_G_DIR, 8'h00);
    wr_reg(`LGP_OFF_DIRECTION, 8'h80);
    ext_val <= 8'h80;
    ext_en <= 8'h80;
    settle();
    chk({7'h00, capture}, 8'h01);
    ext_val <= 8'h00;
    settle();
    chk({7'h00, capture}, 8'h00);
    wr_reg(`LGP_OFF_DIRECTION, 8'h00);
    ext_en <= 8'h00;
    ccp_out <= 1'b1;
    fuse <= 1'b1;
    settle();
    chk({7'h00, pin_out[7]}, 8'h00);
    chk(oe_n, 8'h04);
  endtask

  task automatic t_unmapped;
    wr_reg(3'h7, 8'hff);
    rd_chk(3'h7, 8'h00);
    rd_chk(`LGP_OFF_DIRECTION, 8'h00);
    wr_reg(`LGP_OFF_PORT_G_PINS, 8'h40);
    do_reset();
    t_reset();
  endtask

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    fuse = 1'b1;
    ccp_out = 1'b0;
    ccp_en = 1'b0;
    ext_val = 8'h00;
    ext_en = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_latch_dir();
    t_pullup();
    t_lcd();
    t_ccp();
    t_unmapped();
    final_report();
  end
endmodule // tb
